// ===== hw/ssns_pkg.sv
// Purpose: Constants, types and register map for the standstill/stop block
// Assumes: Speed values are signed, settings unsigned, 0.01 % per count; times 0.1 s/count
// Notes:   One control tick is one millisecond of the 50 MHz clock
`default_nettype none
package ssns_pkg;
  localparam int          CLK_HZ       = 50_000_000;
  localparam int          TICK_US      = 1000;
  localparam int          TICK_CYC_DFLT = CLK_HZ / 1_000_000 * TICK_US;
  localparam int          TICKS_PER_UNIT = 100;   // 0.1 s of 1 ms ticks
  localparam int          COUNTS_PER_UNIT = 100;  // 100.00 % over 0.1 s
  localparam logic [15:0] HYST         = 16'h0032; // 0.50 %
  localparam logic [15:0] FADE_LEVEL   = 16'h0019; // 0.25 %
  localparam logic [15:0] PCT_MAX      = 16'h2710; // 100.00 %
  localparam logic [15:0] DEM_MAX      = 16'h7530; // 300.00 %
  // Register word addresses
  localparam logic [3:0]  A_CTRL   = 4'h0;
  localparam logic [3:0]  A_HALT   = 4'h1;
  localparam logic [3:0]  A_STOPLV = 4'h2;
  localparam logic [3:0]  A_RAMP   = 4'h3;
  localparam logic [3:0]  A_COAST  = 4'h4;
  localparam logic [3:0]  A_LIMIT  = 4'h5;
  localparam logic [3:0]  A_HOLD   = 4'h6;
  localparam logic [3:0]  A_FADE   = 4'h7;
  localparam logic [3:0]  A_CAP    = 4'h8;
  localparam logic [3:0]  A_WIN    = 4'h9;
  localparam logic [3:0]  A_JERKB  = 4'hA;
  localparam logic [3:0]  A_JERKA  = 4'hB;
  localparam logic [3:0]  A_STAT   = 4'hC;
  localparam int          B_QUENCH = 0;
  localparam int          B_REGEN  = 1;
  // Reset values
  localparam logic [15:0] R_HALT   = 16'h0032; // 0.50 %
  localparam logic [15:0] R_STOPLV = 16'h00C8; // 2.00 %
  localparam logic [15:0] R_RAMP   = 16'h0064; // 10.0 s
  localparam logic [15:0] R_COAST  = 16'h0064; // 10.0 s
  localparam logic [15:0] R_LIMIT  = 16'h0258; // 60.0 s
  localparam logic [15:0] R_HOLD   = 16'h000A; // 1.0 s
  localparam logic [15:0] R_FADE   = 16'h0000;
  localparam logic [15:0] R_CAP    = 16'h2710; // 100.00 %
  localparam logic [15:0] R_WIN    = 16'h0064; // 1.00 %
  localparam logic [15:0] R_JERK   = 16'h2710;

  typedef enum logic [1:0] {
    SSNS_OFF  = 2'b00,
    SSNS_RUN  = 2'b01,
    SSNS_STOP = 2'b10,
    SSNS_HOLD = 2'b11
  } ssns_state_e;

  typedef struct packed {
    logic        quench_en;
    logic        regen;
    logic [15:0] halt_level;
    logic [15:0] stop_level;
    logic [15:0] ramp_time;
    logic [15:0] coast_time;
    logic [15:0] stop_limit;
    logic [15:0] holdoff;
    logic [15:0] fade;
    logic [15:0] cap;
    logic [15:0] window;
    logic [15:0] jerk_b;
    logic [15:0] jerk_a;
  } ssns_cfg_s;

  typedef struct packed {
    logic motion_halted_flag;
    logic demand_nil_flag;
    logic fully_halted_flag;
    logic demand_reached_flag;
  } ssns_flags_s;
endpackage
`default_nettype wire

// ===== hw/ssns_top.sv
// Purpose: Standstill detection, loop quench and normal stop sequencing
// Assumes: Speed inputs come from logic on the same clock; pins are async
// Notes:   Ramp steps one count (0.01 %) at a time at the computed rate
`default_nettype none
// How it works
// - Speed halt flag below level, 0.5% hysteresis
// - Demand nil flag below level, hysteresis
// - Fully halted when both flags set
// - Quench loops and firing, keep contactor
// - Quench ends when level exceeded
// - Not-halted indication to enable logic
// - Halt level 0..100.00 %, drives relay
// - Demand input clamped to +-300.00 %
// - Reached flag when ramp error small
// - Second-set jerk settings 0..100.00 %
// - Run removed: ramp demand to zero
// - Non-regen no faster than coast rate
// - Stop done: drop contactor, disable
// - Stop timeout drops contactor and drive
// - Hold contactor for hold-off after stop level
// - Early disable with level and fade
// - Enable low cancels hold-off
// - Outputs: demand, current cap, coast, enable
// - Hold-off starts at stop speed level
// - Ramp time is 100% to zero
module ssns_top #(
  parameter int TICK_CYC = ssns_pkg::TICK_CYC_DFLT,
  parameter int STEP_MUL = ssns_pkg::TICK_CYC_DFLT / ssns_pkg::COUNTS_PER_UNIT
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic [3:0]         addr,
  input  wire logic [15:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic [15:0]             rdata,
  input  wire logic               run_input_pin,
  input  wire logic               enable_input_pin,
  input  wire logic signed [15:0] speed_fb,
  input  wire logic signed [15:0] speed_setpoint,
  input  wire logic signed [15:0] halt_demand_input,
  output logic signed [15:0]      speed_demand,
  output logic [15:0]             fast_halt_current_cap,
  output logic                    line_contactor,
  output logic                    drive_enable,
  output logic                    coast_stop,
  output logic                    not_halted,
  output logic                    loops_quench,
  output logic                    firing_inhibit,
  output logic                    run_indicator,
  output logic                    zero_relay,
  output ssns_pkg::ssns_flags_s   flags
);
  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : v;
  endfunction

  // Flag holds until the magnitude clears level plus hysteresis
  function automatic logic hyst(input logic f, input logic [15:0] m,
                                input logic [15:0] lv);
    hyst = f ? ({1'b0, m} < {1'b0, lv} + {1'b0, ssns_pkg::HYST})
             : (m < lv);
  endfunction

  function automatic logic [15:0] clip(input logic [15:0] v);
    clip = (v > ssns_pkg::PCT_MAX) ? ssns_pkg::PCT_MAX : v;
  endfunction

  // Pin synchronisers
  logic [1:0] run_sync;
  logic [1:0] en_sync;
  logic       run_s;
  logic       en_s;
  always_ff @(posedge clock) begin
    run_sync <= {run_sync[0], run_input_pin};
    en_sync  <= {en_sync[0], enable_input_pin};
  end
  assign run_s = run_sync[1];
  assign en_s  = en_sync[1];

  // Register file
  ssns_pkg::ssns_cfg_s cfg;
  ssns_pkg::ssns_cfg_s next_cfg;
  logic [15:0]         next_rdata;
  ssns_pkg::ssns_state_e state;
  ssns_pkg::ssns_state_e next_state;

  always_comb begin
    next_cfg = cfg;
    if (wr) begin
      case (addr)
        ssns_pkg::A_CTRL: begin
          next_cfg.quench_en = wdata[ssns_pkg::B_QUENCH];
          next_cfg.regen     = wdata[ssns_pkg::B_REGEN];
        end
        ssns_pkg::A_HALT:   next_cfg.halt_level = clip(wdata);
        ssns_pkg::A_STOPLV: next_cfg.stop_level = clip(wdata);
        ssns_pkg::A_RAMP:   next_cfg.ramp_time  = wdata;
        ssns_pkg::A_COAST:  next_cfg.coast_time = wdata;
        ssns_pkg::A_LIMIT:  next_cfg.stop_limit = wdata;
        ssns_pkg::A_HOLD:   next_cfg.holdoff    = wdata;
        ssns_pkg::A_FADE:   next_cfg.fade       = wdata;
        ssns_pkg::A_CAP:    next_cfg.cap        = wdata;
        ssns_pkg::A_WIN:    next_cfg.window     = wdata;
        ssns_pkg::A_JERKB:  next_cfg.jerk_b     = clip(wdata);
        ssns_pkg::A_JERKA:  next_cfg.jerk_a     = clip(wdata);
        default: ;
      endcase
    end
    next_rdata = 16'h0000;
    if (rd) begin
      case (addr)
        ssns_pkg::A_CTRL:   next_rdata = {14'h0000, cfg.regen, cfg.quench_en};
        ssns_pkg::A_HALT:   next_rdata = cfg.halt_level;
        ssns_pkg::A_STOPLV: next_rdata = cfg.stop_level;
        ssns_pkg::A_RAMP:   next_rdata = cfg.ramp_time;
        ssns_pkg::A_COAST:  next_rdata = cfg.coast_time;
        ssns_pkg::A_LIMIT:  next_rdata = cfg.stop_limit;
        ssns_pkg::A_HOLD:   next_rdata = cfg.holdoff;
        ssns_pkg::A_FADE:   next_rdata = cfg.fade;
        ssns_pkg::A_CAP:    next_rdata = cfg.cap;
        ssns_pkg::A_WIN:    next_rdata = cfg.window;
        ssns_pkg::A_JERKB:  next_rdata = cfg.jerk_b;
        ssns_pkg::A_JERKA:  next_rdata = cfg.jerk_a;
        ssns_pkg::A_STAT:   next_rdata = {10'h000, state, flags};
        default:            next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg <= '{1'b0, 1'b1, ssns_pkg::R_HALT, ssns_pkg::R_STOPLV,
               ssns_pkg::R_RAMP, ssns_pkg::R_COAST, ssns_pkg::R_LIMIT,
               ssns_pkg::R_HOLD, ssns_pkg::R_FADE, ssns_pkg::R_CAP,
               ssns_pkg::R_WIN, ssns_pkg::R_JERK, ssns_pkg::R_JERK};
      rdata <= 16'h0000;
    end else begin
      cfg   <= next_cfg;
      rdata <= next_rdata;
    end
  end

  // Standstill detection
  logic signed [15:0] dem_in;
  logic [15:0]        spd_mag;
  logic [15:0]        dem_mag;
  ssns_pkg::ssns_flags_s next_flags;
  logic signed [16:0] ramp_err;

  always_comb begin
    // Demand input saturates at its documented span
    if (halt_demand_input > $signed(ssns_pkg::DEM_MAX))
      dem_in = $signed(ssns_pkg::DEM_MAX);
    else if (halt_demand_input < -$signed(ssns_pkg::DEM_MAX))
      dem_in = -$signed(ssns_pkg::DEM_MAX);
    else
      dem_in = halt_demand_input;
    spd_mag = mag(speed_fb);
    dem_mag = mag(dem_in);
    ramp_err = 17'(speed_setpoint) - 17'(speed_demand);
    next_flags.motion_halted_flag =
      hyst(flags.motion_halted_flag, spd_mag, cfg.halt_level);
    next_flags.demand_nil_flag =
      hyst(flags.demand_nil_flag, dem_mag, cfg.halt_level);
    next_flags.fully_halted_flag = next_flags.motion_halted_flag &&
                                   next_flags.demand_nil_flag;
    next_flags.demand_reached_flag = (ramp_err[16] ? 17'(-ramp_err)
      : ramp_err) < {1'b0, cfg.window};
  end

  always_ff @(posedge clock) begin
    if (rst)
      flags <= '0;
    else
      flags <= next_flags;
  end

  // Stop sequencing: tick prescaler, ramp step divider and stop timer
  logic [23:0]        tick_cnt;
  logic [23:0]        next_tick_cnt;
  logic               tick;
  logic [23:0]        step_cnt;
  logic [23:0]        next_step_cnt;
  logic               step;
  logic [23:0]        tmr;
  logic [23:0]        next_tmr;
  logic [15:0]        rate;
  logic signed [15:0] next_demand;
  logic               go;
  logic               at_stop_lvl;
  logic               early_off;
  logic               next_contactor;
  logic               next_enable;
  logic               next_coast;
  logic               next_quench;

  always_comb begin
    tick = (tick_cnt == 24'(TICK_CYC - 1));
    next_tick_cnt = tick ? 24'h000000 : tick_cnt + 24'h000001;
    // Non-regenerative drives are held to the coast rate
    rate = (!cfg.regen && cfg.coast_time > cfg.ramp_time) ?
           cfg.coast_time : cfg.ramp_time;
    step = (step_cnt + 24'h000001 >= 24'(32'(rate) * STEP_MUL));
    next_step_cnt = step ? 24'h000000 : step_cnt + 24'h000001;
    go = run_s && en_s;
    at_stop_lvl = (spd_mag <= cfg.stop_level);
    early_off = (cfg.stop_level > ssns_pkg::FADE_LEVEL) &&
                (cfg.fade != 16'h0000);
    next_state  = state;
    next_tmr    = tick ? tmr + 24'h000001 : tmr;
    next_demand = speed_demand;
    case (state)
      ssns_pkg::SSNS_OFF: begin
        next_demand = '0;
        next_tmr = '0;
        if (go)
          next_state = ssns_pkg::SSNS_RUN;
      end
      ssns_pkg::SSNS_RUN: begin
        next_demand = dem_in;
        next_tmr = '0;
        if (!en_s)
          next_state = ssns_pkg::SSNS_OFF;
        else if (!run_s) begin
          next_state = ssns_pkg::SSNS_STOP;
          next_step_cnt = '0;
        end
      end
      ssns_pkg::SSNS_STOP: begin
        if (step && speed_demand > 0)
          next_demand = speed_demand - 16'sh0001;
        else if (step && speed_demand < 0)
          next_demand = speed_demand + 16'sh0001;
        if (go) begin
          next_state = ssns_pkg::SSNS_RUN;
        end else if (!en_s) begin
          next_state = ssns_pkg::SSNS_OFF;
        end else if (at_stop_lvl) begin
          next_state = ssns_pkg::SSNS_HOLD;
          next_tmr = '0;
        end else if (tmr >= 24'(32'(cfg.stop_limit) *
                                ssns_pkg::TICKS_PER_UNIT)) begin
          next_state = ssns_pkg::SSNS_OFF;
        end
      end
      ssns_pkg::SSNS_HOLD: begin
        next_demand = '0;
        if (!en_s)
          next_state = ssns_pkg::SSNS_OFF;
        else if (go)
          next_state = ssns_pkg::SSNS_RUN;
        else if (tmr >= 24'(32'(cfg.holdoff) * ssns_pkg::TICKS_PER_UNIT))
          next_state = ssns_pkg::SSNS_OFF;
      end
      default: next_state = ssns_pkg::SSNS_OFF;
    endcase
    if (next_state == ssns_pkg::SSNS_RUN && state != ssns_pkg::SSNS_RUN)
      next_tmr = '0;
    // Contactor stays in through quench and hold-off
    next_contactor = (next_state != ssns_pkg::SSNS_OFF);
    next_enable = next_contactor && en_s &&
      !(next_state == ssns_pkg::SSNS_HOLD && early_off);
    next_coast = (next_state == ssns_pkg::SSNS_OFF);
    next_quench = next_flags.fully_halted_flag && cfg.quench_en &&
                  next_state == ssns_pkg::SSNS_RUN;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state                 <= ssns_pkg::SSNS_OFF;
      tick_cnt              <= '0;
      step_cnt              <= '0;
      tmr                   <= '0;
      speed_demand          <= '0;
      fast_halt_current_cap <= '0;
      line_contactor        <= 1'b0;
      drive_enable          <= 1'b0;
      coast_stop            <= 1'b1;
      not_halted            <= 1'b1;
      loops_quench          <= 1'b0;
      firing_inhibit        <= 1'b1;
      run_indicator         <= 1'b0;
      zero_relay            <= 1'b0;
    end else begin
      state                 <= next_state;
      tick_cnt              <= next_tick_cnt;
      step_cnt              <= next_step_cnt;
      tmr                   <= next_tmr;
      speed_demand          <= next_demand;
      fast_halt_current_cap <= cfg.cap;
      line_contactor        <= next_contactor;
      drive_enable          <= next_enable;
      coast_stop            <= next_coast;
      not_halted            <= !next_flags.fully_halted_flag;
      loops_quench          <= next_quench;
      firing_inhibit        <= next_quench || !next_enable;
      run_indicator         <= next_contactor;
      zero_relay            <= next_flags.motion_halted_flag;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_stop_entry;
    state == ssns_pkg::SSNS_RUN && en_s && !run_s;
  endsequence

  a_halt_set: assert property (!flags.motion_halted_flag &&
    spd_mag < cfg.halt_level |=> flags.motion_halted_flag)
    else $error("speed halt flag not set");
  a_halt_hold: assert property (flags.motion_halted_flag &&
    {1'b0, spd_mag} < {1'b0, cfg.halt_level} + {1'b0, ssns_pkg::HYST}
    |=> flags.motion_halted_flag)
    else $error("speed halt flag dropped inside hysteresis");
  a_nil_set: assert property (!flags.demand_nil_flag &&
    dem_mag >= cfg.halt_level |=> !flags.demand_nil_flag)
    else $error("demand nil flag set above level");
  a_full_halt: assert property (flags.fully_halted_flag
    |-> flags.motion_halted_flag && flags.demand_nil_flag && !not_halted)
    else $error("full halt without both flags");
  a_quench_loops: assert property (loops_quench
    |-> line_contactor && firing_inhibit && run_indicator)
    else $error("quench lost contactor or firing");
  a_stop_entry: assert property (s_stop_entry
    |=> state == ssns_pkg::SSNS_STOP && line_contactor && drive_enable)
    else $error("stop not entered on run removal");
  a_ramp_step: assert property (state == ssns_pkg::SSNS_STOP &&
    next_state == ssns_pkg::SSNS_STOP && step && speed_demand > 0
    |=> speed_demand == $past(speed_demand) - 16'sh0001)
    else $error("ramp step missing");
  a_hold_cancel: assert property (state == ssns_pkg::SSNS_HOLD &&
    !en_s |=> state == ssns_pkg::SSNS_OFF && !line_contactor)
    else $error("hold-off not cancelled");
  a_new_run: assert property (state == ssns_pkg::SSNS_OFF && go
    |=> tmr == 24'h000000 && line_contactor)
    else $error("run start did not clear timer");
endmodule
`default_nettype wire

// ===== verification/ssns_loop_model.sv
// Purpose: Speed loop stand-in turning demand into speed feedback
// Assumes: Same clock as the block; offset models load or drift
// Notes:   Slow mode slews one count a clock, so lag stays bounded
`default_nettype none
module ssns_loop_model (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               slow,
  input  wire logic signed [15:0] offset,
  input  wire logic signed [15:0] speed_demand,
  output logic signed [15:0]      speed_fb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [15:0] target;
  assign target = speed_demand + offset;
  always_ff @(posedge clock) begin
    if (rst) speed_fb <= 16'sh0000;
    else if (!slow) speed_fb <= target;
    else if (speed_fb < target) speed_fb <= speed_fb + 16'sh0001;
    else if (speed_fb > target) speed_fb <= speed_fb - 16'sh0001;
  end
endmodule
`default_nettype wire

// ===== verification/ssns_top_tb.sv
// Purpose: Self-checking bench for standstill and normal stop
// Assumes: Ten clocks a tick, one clock a ramp step unit
// Notes:   Each task drives one scenario and judges it before returning
`default_nettype none
module ssns_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 10000;
  logic                  clock, rst, wr, rd, slow;
  logic                  run_input_pin, enable_input_pin;
  logic [3:0]            addr;
  logic [15:0]           wdata, rdata, fast_halt_current_cap;
  logic signed [15:0]    speed_fb, speed_setpoint, halt_demand_input;
  logic signed [15:0]    speed_demand, offset;
  logic                  line_contactor, drive_enable, coast_stop;
  logic                  not_halted, loops_quench, firing_inhibit;
  logic                  run_indicator, zero_relay;
  ssns_pkg::ssns_flags_s flags;
  int                    error_cnt, n_checks, cycles;

  ssns_top #(.TICK_CYC(10), .STEP_MUL(1)) ssns_top_i (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .run_input_pin(run_input_pin),
    .enable_input_pin(enable_input_pin), .speed_fb(speed_fb),
    .speed_setpoint(speed_setpoint),
    .halt_demand_input(halt_demand_input), .speed_demand(speed_demand),
    .fast_halt_current_cap(fast_halt_current_cap),
    .line_contactor(line_contactor), .drive_enable(drive_enable),
    .coast_stop(coast_stop), .not_halted(not_halted),
    .loops_quench(loops_quench), .firing_inhibit(firing_inhibit),
    .run_indicator(run_indicator), .zero_relay(zero_relay), .flags(flags));
  ssns_loop_model ssns_loop_model_i (
    .clock(clock), .rst(rst), .slow(slow), .offset(offset),
    .speed_demand(speed_demand), .speed_fb(speed_fb));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // A hang counts as a mismatch rather than stalling the run
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic start_run();
    @(posedge clock);
    run_input_pin <= 1'b1;
    enable_input_pin <= 1'b1;
    cyc(10);
  endtask

  task automatic t_regs();
    logic [15:0] e[12] = '{16'h0002, ssns_pkg::R_HALT, ssns_pkg::R_STOPLV,
      ssns_pkg::R_RAMP, ssns_pkg::R_COAST, ssns_pkg::R_LIMIT,
      ssns_pkg::R_HOLD, ssns_pkg::R_FADE, ssns_pkg::R_CAP,
      ssns_pkg::R_WIN, ssns_pkg::R_JERK, ssns_pkg::R_JERK};
    for (int i = 0; i < 12; i++) rchk(4'(i), e[i]);
    rchk(ssns_pkg::A_STAT, 16'h000F);
    chk(line_contactor, 1'b0);
    chk(drive_enable, 1'b0);
    chk(coast_stop, 1'b1);
    chk(fast_halt_current_cap, ssns_pkg::R_CAP);
    wr_reg(ssns_pkg::A_CAP, 16'h1388);
    rchk(ssns_pkg::A_CAP, 16'h1388);
    chk(fast_halt_current_cap, 16'h1388);
    wr_reg(4'hD, 16'h1234);
    rchk(4'hD, 16'h0000);
    wr_reg(ssns_pkg::A_HALT, 16'h3000);
    rchk(ssns_pkg::A_HALT, ssns_pkg::PCT_MAX);
    wr_reg(ssns_pkg::A_JERKB, 16'h3000);
    rchk(ssns_pkg::A_JERKB, ssns_pkg::PCT_MAX);
    wr_reg(ssns_pkg::A_HALT, ssns_pkg::R_HALT);
    $display("end regs");
  endtask

  // Rows walk both hysteresis edges: set below 50, clear at 100 or more
  task automatic t_flags();
    logic signed [15:0] fo[8] = '{16'sh0000, 16'sh003C, 16'sh0064,
      16'sh003C, -16'sh0028, -16'sh0028, -16'sh0028, -16'sh0028};
    logic signed [15:0] dm[8] = '{16'sh0000, 16'sh0000, 16'sh0000,
      16'sh0000, 16'sh0000, -16'sh0063, -16'sh0064, 16'sh0031};
    logic [2:0] e[8] = '{3'h7, 3'h7, 3'h2, 3'h2, 3'h7, 3'h7, 3'h4, 3'h7};
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      offset <= fo[i];
      halt_demand_input <= dm[i];
      cyc(4);
      chk({flags.motion_halted_flag, flags.demand_nil_flag,
           flags.fully_halted_flag}, e[i]);
      chk(not_halted, !e[i][0]);
      chk(zero_relay, e[i][2]);
    end
    chk(flags.demand_reached_flag, 1'b1);
    @(posedge clock) speed_setpoint <= 16'sh0096;
    cyc(4);
    chk(flags.demand_reached_flag, 1'b0);
    @(posedge clock) speed_setpoint <= 16'sh0000;
    offset <= 16'sh0000;
    $display("end flags");
  endtask

  task automatic t_quench();
    wr_reg(ssns_pkg::A_CTRL, 16'h0003);
    start_run();
    chk(loops_quench, 1'b1);
    chk(firing_inhibit, 1'b1);
    chk(line_contactor, 1'b1);
    chk(run_indicator, 1'b1);
    @(posedge clock) halt_demand_input <= 16'sh00C8;
    cyc(5);
    chk(loops_quench, 1'b0);
    chk(firing_inhibit, 1'b0);
    wr_reg(ssns_pkg::A_CTRL, 16'h0002);
    $display("end quench");
  endtask

  // Hold-off of 1000 clocks begins once feedback is within 2.00 %
  task automatic t_stop();
    wr_reg(ssns_pkg::A_HOLD, 16'h0001);
    wr_reg(ssns_pkg::A_RAMP, 16'h0001);
    @(posedge clock) speed_setpoint <= 16'sh012C;
    halt_demand_input <= 16'sh012C;
    slow <= 1'b1;
    cyc(5);
    @(posedge clock) run_input_pin <= 1'b0;
    cyc(900);
    chk(line_contactor, 1'b1);
    chk(drive_enable, 1'b1);
    cyc(500);
    chk(speed_demand, 16'h0000);
    chk(line_contactor, 1'b0);
    chk(drive_enable, 1'b0);
    chk(coast_stop, 1'b1);
    @(posedge clock) slow <= 1'b0;
    $display("end stop");
  endtask

  // Non-regenerative with a 0.2 s coast time: two clocks a count, so
  // 48 counts are gone 100 clocks after the run pin drops
  task automatic t_early();
    wr_reg(ssns_pkg::A_CTRL, 16'h0000);
    wr_reg(ssns_pkg::A_COAST, 16'h0002);
    wr_reg(ssns_pkg::A_FADE, 16'h0001);
    start_run();
    chk(drive_enable, 1'b1);
    @(posedge clock) run_input_pin <= 1'b0;
    cyc(100);
    chk(speed_demand, 16'h00FC);
    cyc(500);
    chk(drive_enable, 1'b0);
    chk(line_contactor, 1'b1);
    @(posedge clock) enable_input_pin <= 1'b0;
    cyc(5);
    chk(line_contactor, 1'b0);
    wr_reg(ssns_pkg::A_FADE, 16'h0000);
    wr_reg(ssns_pkg::A_CTRL, 16'h0002);
    $display("end early");
  endtask

  // Feedback held far above the stop level so only the limit can end it
  task automatic t_timeout();
    wr_reg(ssns_pkg::A_LIMIT, 16'h0001);
    start_run();
    @(posedge clock) offset <= 16'sh03E8;
    cyc(5);
    @(posedge clock) run_input_pin <= 1'b0;
    // Regenerative 0.1 s ramp: one count a clock, 97 gone by here
    cyc(100);
    chk(speed_demand, 16'h00CB);
    cyc(700);
    chk(line_contactor, 1'b1);
    cyc(400);
    chk(line_contactor, 1'b0);
    chk(drive_enable, 1'b0);
    @(posedge clock) offset <= 16'sh0000;
    $display("end timeout");
  endtask

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    slow = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    offset = 16'sh0000;
    run_input_pin = 1'b0;
    enable_input_pin = 1'b0;
    speed_setpoint = 16'sh0000;
    halt_demand_input = 16'sh0000;
    error_cnt = 0;
    n_checks = 0;
    cycles = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    cyc(4);
    t_regs();
    t_flags();
    t_quench();
    t_stop();
    t_early();
    t_timeout();
    report_and_stop();
  end
endmodule
`default_nettype wire
